// File: hdl/atm_cell_word_format.sv
// cell word formatter: utopia side cell layouts, hcs handling, tx fifo
// What this block does
// - 16-bit mode: cell is 27 words
// - 8-bit mode: cell is 54 bytes
// - 16-bit: bit 15 is first bit
// - 16-bit word layout: header, hcs, control or status byte, payload
// - 16-bit: start strobe only on word 1
// - rx: status zero for clean header
// - rx: uncorrectable marked ones, dropped unless enabled
// - rx: corrected header carries 0xAA status
// - tx: internal or inserted hcs select
// - tx: control byte inverts matching hcs bits
// - tx: mask disable ignores control byte
// - 8-bit: bit 7 is first bit
// - 8-bit: start strobe only on byte 1
`timescale 1ns/1ps
`default_nettype none
`include "atm_cell_map.svh"

// =====================================================================
// fifo
// =====================================================================
module cell_fifo #(
  parameter int WIDTH = `TX_FIFO_WIDTH,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic full;
  logic empty;

  wire push = i_valid && !full;
  wire pop = !empty && i_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      full <= (next_count == (AW+1)'(DEPTH));
      empty <= (next_count == '0);
    end
  end
endmodule : cell_fifo

// =====================================================================
// top
// =====================================================================
module atm_cell_word_format (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // mode and control
  input wire logic I_BUS16,
  input wire logic I_PASS_ERRORED_HEADER_EN,
  input wire logic I_TX_HCS_INTERNAL,
  input wire logic I_TX_HEC_MASK_DISABLE,
  // utopia transmit side, from the atm layer
  input wire logic [15:0] I_TX_DATA,
  input wire logic I_TX_VALID,
  input wire logic I_TX_CELL_START_STROBE,
  output logic O_TX_READY,
  // line transmit side, 53 bytes per cell
  output logic [7:0] O_LINE_TX_BYTE,
  output logic O_LINE_TX_VALID,
  output logic O_LINE_TX_SOC,
  input wire logic I_LINE_TX_READY,
  // line receive side, 53 bytes per cell, header already checked
  input wire logic [7:0] I_LINE_RX_BYTE,
  input wire logic I_LINE_RX_VALID,
  input wire logic I_LINE_RX_SOC,
  input wire logic [1:0] I_LINE_RX_HDR_STATUS,
  output logic O_LINE_RX_READY,
  // utopia receive side, to the atm layer
  output logic [15:0] O_RX_DATA,
  output logic O_RX_VALID,
  output logic O_RX_CELL_START_STROBE,
  input wire logic I_RX_READY
);

  // ===================================================================
  // hcs arithmetic
  // ===================================================================
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `HCS_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_byte

  // ===================================================================
  // transmit fifo
  // ===================================================================
  logic tx_in_ready;
  logic [16:0] fifo_out;
  logic fifo_valid;
  logic fifo_pop;

  cell_fifo #(
    .WIDTH(`TX_FIFO_WIDTH),
    .DEPTH(`TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_data({I_TX_CELL_START_STROBE, I_TX_DATA}),
    .i_valid(I_TX_VALID),
    .o_ready(tx_in_ready),
    .o_data(fifo_out),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop)
  );

  // ===================================================================
  // transmit formatter
  // ===================================================================
  atm_cell_pkg::cell_idx_t tx_idx;
  logic [7:0] tx_crc;
  logic [7:0] tx_hcs;
  logic tx_ready;
  logic [7:0] line_tx_byte;
  logic line_tx_valid;
  logic line_tx_soc;

  // both modes walk the same 54 positions; 16-bit words give two each
  wire tx_upper = I_BUS16 && !tx_idx[0];
  wire [7:0] tx_byte = tx_upper ? fifo_out[15:8] : fifo_out[7:0];
  wire tx_soc_in = fifo_out[16];
  wire tx_adv = fifo_valid && (!line_tx_valid || I_LINE_TX_READY);
  wire tx_skip = (tx_idx == '0) && !tx_soc_in;
  wire tx_last = (tx_idx == `CELL_LAST_IDX);
  wire tx_is_hcs = (tx_idx == `CELL_HCS_IDX);
  wire tx_is_ctl = (tx_idx == `CELL_CTL_IDX);
  wire [7:0] tx_crc_next = (tx_idx == '0) ? crc8_byte(8'h00, tx_byte)
    : crc8_byte(tx_crc, tx_byte);
  wire [7:0] tx_mask = I_TX_HEC_MASK_DISABLE ? 8'h00 : tx_byte;
  wire [7:0] tx_hcs_sel = I_TX_HCS_INTERNAL ? (tx_crc ^ `HCS_COSET) : tx_byte;
  wire tx_emit = !tx_skip && !tx_is_hcs;
  wire [7:0] tx_out_byte = tx_is_ctl ? (tx_hcs ^ tx_mask) : tx_byte;

  // a word leaves the fifo after its low byte, or at once in 8-bit mode
  assign fifo_pop = tx_adv && (tx_skip || !I_BUS16 || tx_idx[0]);

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_idx <= '0;
      tx_crc <= 8'h00;
      tx_hcs <= 8'h00;
    end else if (tx_adv && !tx_skip) begin
      tx_idx <= tx_last ? '0 : tx_idx + 6'd1;
      if (tx_idx <= `CELL_HDR_LAST) begin
        tx_crc <= tx_crc_next;
      end
      if (tx_is_hcs) begin
        tx_hcs <= tx_hcs_sel;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      line_tx_byte <= 8'h00;
      line_tx_valid <= 1'b0;
      line_tx_soc <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= tx_in_ready;
      if (tx_adv) begin
        line_tx_byte <= tx_out_byte;
        line_tx_valid <= tx_emit;
        line_tx_soc <= tx_emit && (tx_idx == '0);
      end else if (I_LINE_TX_READY) begin
        line_tx_valid <= 1'b0;
        line_tx_soc <= 1'b0;
      end
    end
  end

  // ===================================================================
  // receive formatter
  // ===================================================================
  atm_cell_pkg::cell_idx_t rx_idx;
  atm_cell_pkg::hdr_status_e rx_status;
  atm_cell_pkg::hdr_status_e rx_status_in;
  logic rx_drop;
  logic [7:0] rx_hold;
  logic [15:0] rx_data;
  logic rx_valid;
  logic rx_soc;
  logic line_rx_ready;
  logic [7:0] rx_st_byte;

  assign rx_status_in = atm_cell_pkg::hdr_status_e'(I_LINE_RX_HDR_STATUS);

  always_comb begin
    case (rx_status)
      atm_cell_pkg::HDR_OK: rx_st_byte = `HCS_ST_OK;
      atm_cell_pkg::HDR_CORRECTED: rx_st_byte = `HCS_ST_CORR;
      default: rx_st_byte = `HCS_ST_BAD;
    endcase
  end

  wire rx_space = !rx_valid || I_RX_READY;
  wire rx_is_st = (rx_idx == `CELL_CTL_IDX);
  wire rx_take = I_LINE_RX_VALID && line_rx_ready;
  wire rx_start = (rx_idx == '0);
  wire rx_skip = rx_start && !I_LINE_RX_SOC;
  wire rx_step = rx_is_st ? rx_space : (rx_take && !rx_skip);
  wire rx_bad = (rx_status_in == atm_cell_pkg::HDR_UNCORRECTABLE)
    || (rx_status_in == atm_cell_pkg::HDR_RESERVED);
  wire rx_drop_now = rx_start ? (rx_bad && !I_PASS_ERRORED_HEADER_EN) : rx_drop;
  wire [7:0] rx_byte = rx_is_st ? rx_st_byte : I_LINE_RX_BYTE;
  wire rx_last = (rx_idx == `CELL_LAST_IDX);
  // 16-bit words form on the second byte of each pair, first byte high
  wire rx_emit = rx_step && !rx_drop_now && (!I_BUS16 || rx_idx[0]);
  wire [15:0] rx_word = I_BUS16 ? {rx_hold, rx_byte} : {8'h00, rx_byte};
  wire rx_first = I_BUS16 ? (rx_idx == `CELL_W1_LOW_IDX) : rx_start;
  wire next_rx_valid = rx_emit || (rx_valid && !I_RX_READY);
  wire [5:0] next_rx_idx = rx_step ? (rx_last ? 6'd0 : rx_idx + 6'd1) : rx_idx;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_idx <= '0;
      rx_status <= atm_cell_pkg::HDR_OK;
      rx_drop <= 1'b0;
      rx_hold <= 8'h00;
    end else begin
      rx_idx <= next_rx_idx;
      if (rx_step && rx_start) begin
        rx_status <= rx_status_in;
        rx_drop <= rx_drop_now;
      end
      if (rx_step && !rx_idx[0]) begin
        rx_hold <= rx_byte;
      end
    end
  end

  // line ready is granted only when the output word will be free
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_data <= 16'h0000;
      rx_valid <= 1'b0;
      rx_soc <= 1'b0;
      line_rx_ready <= 1'b0;
    end else begin
      rx_valid <= next_rx_valid;
      if (rx_emit) begin
        rx_data <= rx_word;
        rx_soc <= rx_first;
      end else if (I_RX_READY) begin
        rx_soc <= 1'b0;
      end
      line_rx_ready <= !next_rx_valid && (next_rx_idx != `CELL_CTL_IDX);
    end
  end

  // ===================================================================
  // outputs
  // ===================================================================
  assign O_TX_READY = tx_ready;
  assign O_LINE_TX_BYTE = line_tx_byte;
  assign O_LINE_TX_VALID = line_tx_valid;
  assign O_LINE_TX_SOC = line_tx_soc;
  assign O_LINE_RX_READY = line_rx_ready;
  assign O_RX_DATA = rx_data;
  assign O_RX_VALID = rx_valid;
  assign O_RX_CELL_START_STROBE = rx_soc;

endmodule : atm_cell_word_format
`default_nettype wire

// File: hdl/atm_cell_map.svh
// offsets, codes and sizes for the cell word formatter
`ifndef ATM_CELL_MAP_SVH
`define ATM_CELL_MAP_SVH

`define CELL_LAST_IDX 6'd53
`define CELL_HDR_LAST 6'd3
`define CELL_HCS_IDX 6'd4
`define CELL_CTL_IDX 6'd5
`define CELL_W1_LOW_IDX 6'd1
`define HCS_POLY 8'h07
`define HCS_COSET 8'h55
`define HCS_ST_OK 8'h00
`define HCS_ST_CORR 8'hAA
`define HCS_ST_BAD 8'hFF
`define TX_FIFO_WIDTH 17
`define TX_FIFO_DEPTH 16

`endif

// File: hdl/atm_cell_pkg.sv
// types shared by the cell word formatter
package atm_cell_pkg;

  // header check result delivered with the first line byte of a cell
  typedef enum logic [1:0] {
    HDR_OK,
    HDR_CORRECTED,
    HDR_UNCORRECTABLE,
    HDR_RESERVED
  } hdr_status_e;

  typedef logic [5:0] cell_idx_t;

endpackage : atm_cell_pkg

// File: verification/atm_cell_word_format_monitor.sv
// port assertions for the cell word formatter
`timescale 1ns/1ps
`default_nettype none
// =========================================
// checker
module atm_cell_word_format_chk (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_BUS16,
  input wire logic I_RX_READY,
  input wire logic [15:0] O_RX_DATA,
  input wire logic O_RX_VALID,
  input wire logic O_RX_CELL_START_STROBE,
  input wire logic I_LINE_TX_READY,
  input wire logic [7:0] O_LINE_TX_BYTE,
  input wire logic O_LINE_TX_VALID,
  input wire logic O_LINE_TX_SOC
);
  logic [5:0] n_rx;
  logic [5:0] n_ln;
  logic m16;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  sequence rx_take; O_RX_VALID && I_RX_READY; endsequence
  sequence rx_soc; O_RX_VALID && I_RX_READY && O_RX_CELL_START_STROBE; endsequence
  sequence ln_soc; O_LINE_TX_VALID && I_LINE_TX_READY && O_LINE_TX_SOC; endsequence
  // units taken since the last start strobe
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      n_rx <= 6'h00;
      n_ln <= 6'h00;
      m16 <= 1'b0;
    end else begin
      if (O_RX_VALID && I_RX_READY) n_rx <= O_RX_CELL_START_STROBE ? 6'h01 : n_rx + 6'h01;
      if (O_RX_VALID && I_RX_READY && O_RX_CELL_START_STROBE) m16 <= I_BUS16;
      if (O_LINE_TX_VALID && I_LINE_TX_READY) n_ln <= O_LINE_TX_SOC ? 6'h01 : n_ln + 6'h01;
    end
  end
  chk_rx_cell_len: assert property (rx_soc |-> n_rx == 6'h00
    || n_rx == (m16 ? 6'h1B : 6'h36))
    else $error("rx cell length wrong");
  chk_line_cell_len: assert property (ln_soc |-> n_ln == 6'h00 || n_ln == 6'h35)
    else $error("line cell length wrong");
  chk_rx_soc_once: assert property (rx_soc ##1 rx_take |-> !O_RX_CELL_START_STROBE)
    else $error("rx strobe past first unit");
  chk_rx_soc_valid: assert property (O_RX_CELL_START_STROBE |-> O_RX_VALID)
    else $error("rx strobe without valid");
  chk_line_soc_valid: assert property (O_LINE_TX_SOC |-> O_LINE_TX_VALID)
    else $error("line strobe without valid");
  chk_rx_word_hold: assert property (O_RX_VALID && !I_RX_READY
    |=> O_RX_VALID && $stable(O_RX_DATA))
    else $error("rx word changed before taken");
  chk_line_byte_hold: assert property (O_LINE_TX_VALID && !I_LINE_TX_READY
    |=> O_LINE_TX_VALID && $stable(O_LINE_TX_BYTE))
    else $error("line byte changed before taken");
  chk_rx_upper_zero: assert property (!I_BUS16 && O_RX_VALID |-> O_RX_DATA[15:8] == 8'h00)
    else $error("rx upper byte set in byte mode");
endmodule : atm_cell_word_format_chk
bind atm_cell_word_format atm_cell_word_format_chk atm_cell_word_format_chk_inst (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_BUS16(I_BUS16), .I_RX_READY(I_RX_READY),
  .O_RX_DATA(O_RX_DATA), .O_RX_VALID(O_RX_VALID), .O_RX_CELL_START_STROBE(O_RX_CELL_START_STROBE),
  .I_LINE_TX_READY(I_LINE_TX_READY), .O_LINE_TX_BYTE(O_LINE_TX_BYTE),
  .O_LINE_TX_VALID(O_LINE_TX_VALID), .O_LINE_TX_SOC(O_LINE_TX_SOC));
`default_nettype wire

// File: verification/atm_layer_model.sv
// atm layer model: receive sink with periodic stalls
`timescale 1ns/1ps
`default_nettype none
// =========================================
// sink
module atm_layer_model #(
  parameter int STALL = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_ready
);
  logic [3:0] cnt;
  // takes whole units, stalls one cycle in STALL
  assign o_ready = (cnt != 4'h0);
  always_ff @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
    end else begin
      cnt <= (cnt == 4'(STALL - 1)) ? 4'h0 : cnt + 4'h1;
    end
  end
endmodule : atm_layer_model
`default_nettype wire

// File: verification/atm_cell_word_format_tb_top.sv
// testbench for the cell word formatter
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", s, e, g); end end
// =========================================
// bench
module atm_cell_word_format_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic b16 = 1'b1;
  logic pass = 1'b0;
  logic hin = 1'b0;
  logic mdis = 1'b0;
  logic [15:0] td = 16'h0000;
  logic tv = 1'b0;
  logic ts = 1'b0;
  logic lt_rdy = 1'b1;
  logic [7:0] lb = 8'h00;
  logic lv = 1'b0;
  logic ls = 1'b0;
  logic [1:0] lst = 2'h0;
  wire logic tx_rdy, ltv, ltsoc, lr_rdy, rxv, rxsoc, rx_rdy;
  wire logic [7:0] ltb;
  wire logic [15:0] rxd;
  logic [16:0] rxq [$];
  logic [8:0] txq [$];
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  atm_cell_word_format atm_cell_word_format_inst (.I_MCLK(clk), .I_RST_N(rst_n), .I_BUS16(b16),
    .I_PASS_ERRORED_HEADER_EN(pass), .I_TX_HCS_INTERNAL(hin), .I_TX_HEC_MASK_DISABLE(mdis),
    .I_TX_DATA(td), .I_TX_VALID(tv), .I_TX_CELL_START_STROBE(ts), .O_TX_READY(tx_rdy),
    .O_LINE_TX_BYTE(ltb), .O_LINE_TX_VALID(ltv), .O_LINE_TX_SOC(ltsoc), .I_LINE_TX_READY(lt_rdy),
    .I_LINE_RX_BYTE(lb), .I_LINE_RX_VALID(lv), .I_LINE_RX_SOC(ls), .I_LINE_RX_HDR_STATUS(lst),
    .O_LINE_RX_READY(lr_rdy), .O_RX_DATA(rxd), .O_RX_VALID(rxv), .O_RX_CELL_START_STROBE(rxsoc),
    .I_RX_READY(rx_rdy));
  atm_layer_model atm_layer_model_inst (.i_clk(clk), .i_rst_n(rst_n), .o_ready(rx_rdy));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (rxv && rx_rdy) rxq.push_back({rxsoc, rxd});
    if (ltv && lt_rdy) txq.push_back({ltsoc, ltb});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // header check octet: generator x^8+x^2+x+1 over the four header octets, then 0x55
  function automatic logic [7:0] hec8(input logic [31:0] hdr);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 31; b >= 0; b--) r = {r[6:0], 1'b0} ^ ((r[7] ^ hdr[b]) ? 8'h07 : 8'h00);
    return r ^ 8'h55;
  endfunction : hec8
  // send one cell with the line sink stalled 40 cycles, checking that the fifo refuses before release
  // offers every other cycle: the registered ready lags the fifo by one cycle
  task automatic tx_cell(input logic m16, input logic [7:0] mask, input logic dis,
    input logic inner);
    logic [7:0] u [54];
    int n;
    @(negedge clk);
    b16 = m16;
    mdis = dis;
    hin = inner;
    lt_rdy = 1'b0;
    txq.delete();
    for (int i = 0; i < 54; i++) u[i] = 8'(i * 5 + 3);
    u[5] = mask;
    n = m16 ? 27 : 54;
    fork
      for (int i = 0; i < n;) begin
        @(negedge clk);
        tv = tx_rdy && !tv;
        ts = (i == 0);
        td = m16 ? {u[2*i], u[2*i+1]} : {8'h00, u[i]};
        if (tv) i++;
      end
      begin
        repeat (40) @(negedge clk);
        `CHK("tx_full", 1'b0, tx_rdy)
        lt_rdy = 1'b1;
      end
    join
    @(negedge clk) tv = 1'b0;
    for (int k = 0; k < 400 && txq.size() < 53; k++) @(posedge clk);
    `CHK("tx_len", 53, txq.size())
    for (int i = 0; i < 53; i++) begin
      int j;
      logic [7:0] e;
      j = (i < 5) ? i : i + 1;
      e = (i == 4 && inner) ? hec8({u[0], u[1], u[2], u[3]}) : u[j];
      e = e ^ ((i == 4 && !dis) ? mask : 8'h00);
      `CHK("tx_byte", {1'(i == 0), e}, txq[i])
    end
  endtask : tx_cell
  // feed one line cell and judge the delivered units
  task automatic rx_cell(input logic m16, input logic [1:0] st, input logic p, input logic [7:0] sb);
    logic [7:0] u [54];
    int n;
    @(negedge clk);
    b16 = m16;
    pass = p;
    rxq.delete();
    for (int i = 0; i < 54; i++) u[i] = 8'(i * 7 + 1);
    u[5] = sb;
    n = (sb == 8'hFF && !p) ? 0 : (m16 ? 27 : 54);
    for (int i = 0; i < 54;) begin
      @(negedge clk);
      if (i == 5) i++;
      lv = lr_rdy;
      ls = (i == 0);
      lb = u[i];
      lst = st;
      if (lr_rdy) i++;
    end
    @(negedge clk) lv = 1'b0;
    for (int k = 0; k < 400 && rxq.size() < n; k++) @(posedge clk);
    `CHK("rx_len", n, rxq.size())
    for (int i = 0; i < n; i++) begin
      logic [15:0] w;
      w = m16 ? {u[2*i], u[2*i+1]} : {8'h00, u[i]};
      `CHK("rx_word", {1'(i == 0), w}, rxq[i])
    end
  endtask : rx_cell
  task automatic sc_tx_mask();
    tx_cell(1'b1, 8'h81, 1'b0, 1'b0);
  endtask : sc_tx_mask
  task automatic sc_tx_nomask();
    tx_cell(1'b0, 8'h3C, 1'b1, 1'b0);
  endtask : sc_tx_nomask
  task automatic sc_tx_internal();
    tx_cell(1'b1, 8'h01, 1'b0, 1'b1);
    tx_cell(1'b0, 8'h20, 1'b1, 1'b1);
  endtask : sc_tx_internal
  task automatic sc_rx_status();
    rx_cell(1'b1, 2'h0, 1'b0, 8'h00);
    rx_cell(1'b1, 2'h1, 1'b0, 8'hAA);
    rx_cell(1'b0, 2'h2, 1'b1, 8'hFF);
    rx_cell(1'b0, 2'h3, 1'b0, 8'hFF);
    rx_cell(1'b0, 2'h1, 1'b0, 8'hAA);
  endtask : sc_rx_status
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    sc_tx_mask();
    sc_tx_nomask();
    sc_tx_internal();
    sc_rx_status();
    results();
  end
endmodule : atm_cell_word_format_tb_top
`default_nettype wire
